// File: design/sms_fifo.sv
// Parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps
module sms_fifo #(
   parameter int W = 8,
   parameter int D = 16,
   parameter int AW = 4
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Fill side
   input wire logic [W-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // Drain side
   output logic [W-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   logic [W-1:0] mem [D];
   logic [AW:0] wp_r;
   logic [AW:0] rp_r;
   logic full;
   logic empty;
   logic push;
   logic pop;

   // Pointer compare with wrap bit
   assign empty = (wp_r == rp_r);
   assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
   assign in_ready = ~full;
   assign out_valid = ~empty;
   assign out_data = mem[rp_r[AW-1:0]];
   assign push = in_valid & ~full;
   assign pop = out_ready & ~empty;

   // Storage write
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wp_r[AW-1:0]] <= in_data;
      end
   end

   // Pointer update
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         if (push) begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
      end
   end
endmodule : sms_fifo

// File: design/sms_pkg.sv
// Shared constants for the serial master/slave block
// Contract
// - Idle master starts transfer on buffer write
// - Empty shifter loads pending transmit byte
// - After eight bits, store byte, load next
// - One shifter shifts in and out together
// - All four polarity/phase modes are selectable
// - Phase zero samples leading, changes trailing
// - Master halves input clock into bit clock
// - Master interrupt on transmit empty or complete
// - Status read clears all but buffer flags
// - Interrupt is a level until flag clears
// - Slave shifts only on external bit clock
// - Slave select comes only from input pin
// - Slave interrupt on receive full or complete
// - Select never gates output; first bit shown
package sms_pkg;
   // Data path
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_AW = 4;
   localparam int CNT_W = 3;
   localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
   localparam logic [CNT_W-1:0] CNT_LAST = 3'h7;
   // Status register bit positions
   localparam int ST_RX_FULL = 3;
   localparam int ST_TX_EMPTY = 4;
   localparam int ST_DONE = 5;
   localparam int ST_OVERRUN = 6;
   localparam int ST_W = 8;
   // Values after reset
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
   localparam logic [ST_W-1:0] STATUS_RST = 8'h10;
   // Master engine states
   typedef enum logic [0:0] {SMS_IDLE, SMS_XFER} sms_state_t;
endpackage : sms_pkg

// File: design/sms_top.sv
// Serial master/slave transceiver: shifter, buffers, flags, interrupt
`timescale 1ns/1ps
module sms_top
   import sms_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Configuration
   input wire logic enable,
   input wire logic master_mode,
   input wire logic cpol,
   input wire logic cpha,
   input wire logic lsb_first_option,
   input wire logic int_src_sel,
   input wire logic int_enable,
   // Master bit-rate source, one pulse per half bit
   input wire logic clk2x_tick,
   // Software transmit side
   input wire logic [DATA_W-1:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   // Software receive side
   input wire logic rx_rd,
   output logic [DATA_W-1:0] rx_data_r,
   // Software status side
   input wire logic stat_rd,
   output logic [ST_W-1:0] status_r,
   output logic irq_r,
   // Master pins
   output logic sclk_out_r,
   input wire logic miso_in,
   // Slave pins
   input wire logic sclk_in,
   input wire logic mosi_in,
   input wire logic ss_in_n,
   // Serial data out, shared by both roles
   output logic ser_out_r
);
   sms_state_t state_r;
   sms_state_t state_nxt;
   logic [DATA_W-1:0] sh_r;
   logic [DATA_W-1:0] sh_shifted;
   logic [DATA_W-1:0] txb_r;
   logic [CNT_W-1:0] cnt_r;
   logic txb_full_r;
   logic sh_full_r;
   logic samp_r;
   logic rx_full_r;
   logic done_r;
   logic overrun_r;
   logic sclk_m_r;
   logic sclk_s_r;
   logic sclk_d_r;
   logic mosi_m_r;
   logic mosi_s_r;
   logic ss_m_r;
   logic ss_s_r;
   logic [DATA_W-1:0] fifo_data;
   logic fifo_valid;
   logic fifo_pop;
   logic lead_ev;
   logic trail_ev;
   logic done_ev;
   logic din;
   logic busy;
   logic idle_load;
   logic load_sh;
   logic slv_act;
   logic slv_edge;
   logic int_cause;

   // Shift one bit in at the end opposite the outgoing bit
   function automatic logic [DATA_W-1:0] shift_in(
      input logic [DATA_W-1:0] v,
      input logic b,
      input logic lsb
   );
      logic [DATA_W-1:0] r;
      r = lsb ? {b, v[DATA_W-1:1]} : {v[DATA_W-2:0], b};
      return r;
   endfunction : shift_in

   // Bit that leaves first from the shifter
   function automatic logic out_bit(
      input logic [DATA_W-1:0] v,
      input logic lsb
   );
      logic r;
      r = lsb ? v[0] : v[DATA_W-1];
      return r;
   endfunction : out_bit

   // Write queue ahead of the transmit buffer
   sms_fifo #(
      .W(DATA_W),
      .D(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_txq (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .in_data(tx_data),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop)
   );

   // Slave pins pass two flops before any logic looks at them
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sclk_m_r <= 1'b0;
         sclk_s_r <= 1'b0;
         sclk_d_r <= 1'b0;
         mosi_m_r <= 1'b0;
         mosi_s_r <= 1'b0;
         ss_m_r <= 1'b1;
         ss_s_r <= 1'b1;
      end else begin
         sclk_m_r <= sclk_in;
         sclk_s_r <= sclk_m_r;
         sclk_d_r <= sclk_s_r;
         mosi_m_r <= mosi_in;
         mosi_s_r <= mosi_m_r;
         ss_m_r <= ss_in_n;
         ss_s_r <= ss_m_r;
      end
   end

   // Slave active only while the select pin is low
   assign slv_act = enable & ~master_mode & ~ss_s_r;
   // Slave edges come only from the external clock
   assign slv_edge = slv_act & (sclk_s_r != sclk_d_r);

   // Leading edge leaves the idle level, trailing returns to it
   always_comb begin
      lead_ev = 1'b0;
      trail_ev = 1'b0;
      if (master_mode) begin
         if (state_r == SMS_XFER && clk2x_tick) begin
            lead_ev = (sclk_out_r == cpol);
            trail_ev = (sclk_out_r != cpol);
         end
      end else if (slv_edge) begin
         lead_ev = (sclk_s_r != cpol);
         trail_ev = (sclk_s_r == cpol);
      end
   end

   // Incoming data line for the current role
   assign din = master_mode ? miso_in : mosi_s_r;
   assign sh_shifted = shift_in(sh_r, cpha ? din : samp_r, lsb_first_option);
   assign done_ev = trail_ev & (cnt_r == CNT_LAST);

   // Busy means a byte is part way through
   assign busy = master_mode ? (state_r == SMS_XFER) : (cnt_r != CNT_ZERO);
   // Empty shifter takes the pending byte
   assign idle_load = enable & txb_full_r & ~sh_full_r & ~busy;
   assign load_sh = idle_load | (done_ev & txb_full_r);

   // Queue refills the buffer when it empties
   assign fifo_pop = fifo_valid & ~txb_full_r;

   // Transmit buffer
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         txb_r <= DATA_RST;
         txb_full_r <= 1'b0;
      end else if (fifo_pop) begin
         txb_r <= fifo_data;
         txb_full_r <= 1'b1;
      end else if (load_sh) begin
         txb_full_r <= 1'b0;
      end
   end

   // Master state sequencing
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         SMS_IDLE: begin
            if (master_mode && idle_load) begin
               state_nxt = SMS_XFER;
            end
         end
         SMS_XFER: begin
            if (!enable || !master_mode) begin
               state_nxt = SMS_IDLE;
            end else if (done_ev && !txb_full_r) begin
               state_nxt = SMS_IDLE;
            end
         end
         default: begin
            state_nxt = SMS_IDLE;
         end
      endcase
   end

   // Master state register
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= SMS_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Bit clock: each half-bit pulse toggles, giving even duty
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sclk_out_r <= 1'b0;
      end else if (master_mode && state_r == SMS_XFER && clk2x_tick) begin
         sclk_out_r <= ~sclk_out_r;
      end else if (state_r != SMS_XFER || !master_mode) begin
         sclk_out_r <= cpol;
      end
   end

   // Bit counter, cleared when the slave is deselected
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r <= CNT_ZERO;
      end else if (!enable || (!master_mode && !slv_act)) begin
         cnt_r <= CNT_ZERO;
      end else if (trail_ev) begin
         cnt_r <= cnt_r + 3'h1;
      end
   end

   // Phase zero keeps the leading-edge sample until trailing
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         samp_r <= 1'b0;
      end else if (lead_ev && !cpha) begin
         samp_r <= din;
      end
   end

   // Shared shifter and its loaded mark
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sh_r <= DATA_RST;
         sh_full_r <= 1'b0;
      end else if (load_sh) begin
         sh_r <= txb_r;
         sh_full_r <= 1'b1;
      end else if (trail_ev) begin
         sh_r <= sh_shifted;
         if (done_ev) begin
            sh_full_r <= 1'b0;
         end
      end
   end

   // Serial out: trailing edges for phase zero, leading for one
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ser_out_r <= 1'b0;
      end else if (load_sh) begin
         ser_out_r <= out_bit(txb_r, lsb_first_option);
      end else if (trail_ev && !cpha) begin
         ser_out_r <= out_bit(sh_shifted, lsb_first_option);
      end else if (lead_ev && cpha) begin
         ser_out_r <= out_bit(sh_r, lsb_first_option);
      end else if (done_ev) begin
         ser_out_r <= out_bit(sh_shifted, lsb_first_option);
      end
   end

   // Receive buffer takes the byte at the eighth bit
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_data_r <= DATA_RST;
      end else if (done_ev) begin
         rx_data_r <= sh_shifted;
      end
   end

   // Receive full: set by a byte, cleared by a read, set wins
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_full_r <= 1'b0;
      end else if (done_ev) begin
         rx_full_r <= 1'b1;
      end else if (rx_rd) begin
         rx_full_r <= 1'b0;
      end
   end

   // Complete flag: cleared by a status read, set wins
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         done_r <= 1'b0;
      end else if (done_ev) begin
         done_r <= 1'b1;
      end else if (stat_rd) begin
         done_r <= 1'b0;
      end
   end

   // Overrun: new byte while the last is still unread
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         overrun_r <= 1'b0;
      end else if (done_ev && rx_full_r && !rx_rd) begin
         overrun_r <= 1'b1;
      end else if (stat_rd) begin
         overrun_r <= 1'b0;
      end
   end

   // Status image as software sees it
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         status_r <= STATUS_RST;
      end else begin
         status_r <= '0;
         status_r[ST_RX_FULL] <= rx_full_r;
         status_r[ST_TX_EMPTY] <= ~txb_full_r;
         status_r[ST_DONE] <= done_r;
         status_r[ST_OVERRUN] <= overrun_r;
      end
   end

   // Interrupt source follows role and the source select
   always_comb begin
      if (int_src_sel) begin
         int_cause = done_r;
      end else if (master_mode) begin
         int_cause = ~txb_full_r;
      end else begin
         int_cause = rx_full_r;
      end
   end

   // Level output: stays up until the flag is cleared, no re-trigger
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= int_enable & enable & int_cause;
      end
   end
endmodule : sms_top

// File: verif/sms_peer.sv
// Serial slave peer model on the far side of the master
`timescale 1ns/1ps
module sms_peer (
   // Link pins
   input wire logic sclk,
   input wire logic mosi,
   output logic miso,
   // Mode and data
   input wire logic cpol,
   input wire logic cpha,
   input wire logic lsb,
   input wire logic arm,
   input wire logic [7:0] tx_byte,
   output logic [7:0] rx_byte
);
   logic [7:0] sr;
   // Line value just before an edge; the master may move it on that same edge
   logic mosi_h;
   always @(mosi) mosi_h <= #1 mosi;
   // Show next bit, then advance
   task automatic put;
      miso = lsb ? sr[0] : sr[7];
      sr = lsb ? sr >> 1 : sr << 1;
   endtask : put
   initial begin
      miso = 1'b0;
      sr = 8'h00;
      rx_byte = 8'h00;
   end
   // No select line: the peer always listens
   always @(posedge arm) begin
      sr = tx_byte;
      if (!cpha) put();
      else miso = ~miso;
   end
   // Leading edge leaves the idle level
   always @(sclk) begin
      if ((sclk != cpol) == !cpha) rx_byte = lsb ? {mosi_h, rx_byte[7:1]} : {rx_byte[6:0], mosi_h};
      else put();
   end
endmodule : sms_peer

// File: verif/sms_props.sv
// Port checker for the serial master/slave block
`timescale 1ns/1ps
module sms_props
   import sms_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Inputs
   input wire logic enable,
   input wire logic master_mode,
   input wire logic cpol,
   input wire logic int_src_sel,
   input wire logic int_enable,
   input wire logic clk2x_tick,
   input wire logic tx_valid,
   input wire logic stat_rd,
   // Outputs
   input wire logic tx_ready,
   input wire logic [ST_W-1:0] status_r,
   input wire logic irq_r,
   input wire logic sclk_out_r,
   input wire logic ser_out_r
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // Master bit clock moves only on a tick
   property p_sclk_tick;
      master_mode && $stable(master_mode) && !clk2x_tick && $stable(cpol) && $stable(enable) && $past(reset_n)
         |=> $stable(sclk_out_r);
   endproperty
   a_sclk_tick: assert property (p_sclk_tick) else $error("sclk moved without tick");
   // Slave never makes a bit clock
   property p_slave_quiet;
      !master_mode && !$past(master_mode) && $stable(cpol) && $stable(enable) |=> $stable(sclk_out_r);
   endproperty
   a_slave_quiet: assert property (p_slave_quiet) else $error("slave drove sclk");
   // Master data moves only on a tick or a fresh load
   property p_data_tick;
      master_mode && $past(master_mode) && enable && $past(enable) && $past(enable, 2) && !clk2x_tick
         && !tx_valid && !$past(tx_valid) && !$past(tx_valid, 2) && !$past(tx_valid, 3) |=> $stable(ser_out_r);
   endproperty
   a_data_tick: assert property (p_data_tick) else $error("data moved without tick");
   // Unused status bits stay low
   property p_status_rsvd;
      status_r[2:0] == 3'h0 && !status_r[7];
   endproperty
   a_status_rsvd: assert property (p_status_rsvd) else $error("reserved status set");
   // Status read clears completion when no tick can set it
   property p_done_clear;
      stat_rd && master_mode && !clk2x_tick && !$past(clk2x_tick) |-> ##[1:2] !status_r[ST_DONE];
   endproperty
   a_done_clear: assert property (p_done_clear) else $error("done not cleared");
   // No interrupt while masked
   property p_irq_off;
      !(enable && int_enable) |=> !irq_r;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq while masked");
   // Master level interrupt on empty buffer
   property p_irq_empty;
      (enable && int_enable && master_mode && !int_src_sel && status_r[ST_TX_EMPTY]) [*3] |-> irq_r;
   endproperty
   a_irq_empty: assert property (p_irq_empty) else $error("no irq on empty");
   // Completion source in either role
   property p_irq_done;
      (enable && int_enable && int_src_sel && status_r[ST_DONE]) [*3] |-> irq_r;
   endproperty
   a_irq_done: assert property (p_irq_done) else $error("no irq on done");
   // Slave level interrupt on full receive buffer
   property p_irq_full;
      (enable && int_enable && !master_mode && !int_src_sel && status_r[ST_RX_FULL]) [*3] |-> irq_r;
   endproperty
   a_irq_full: assert property (p_irq_full) else $error("no irq on full");
   // Main scenarios
   c_done: cover property ($rose(status_r[ST_DONE]));
   c_irq: cover property ($rose(irq_r));
   c_full: cover property (!tx_ready);
endmodule : sms_props
bind sms_top sms_props sms_props_i (.core_clk(core_clk), .reset_n(reset_n), .enable(enable),
   .master_mode(master_mode), .cpol(cpol), .int_src_sel(int_src_sel), .int_enable(int_enable),
   .clk2x_tick(clk2x_tick), .tx_valid(tx_valid), .stat_rd(stat_rd), .tx_ready(tx_ready),
   .status_r(status_r), .irq_r(irq_r), .sclk_out_r(sclk_out_r), .ser_out_r(ser_out_r));

// File: verif/spi_master_slave_block_test.sv
// Self-checking bench for the serial master/slave block
`timescale 1ns/1ps
module spi_master_slave_block_test
   import sms_pkg::*;
();
   logic core_clk, reset_n, enable, master_mode, cpol, cpha, lsb, int_src_sel, int_enable;
   logic clk2x_tick, tick_en, tx_valid, tx_ready, rx_rd, stat_rd, irq_r, sclk_out_r, ser_out_r;
   logic miso, sclk_in, mosi_in, ss_in_n, arm;
   logic [7:0] tx_data, rx_data_r, status_r, pb, prx, sg;
   int n_mismatch = 0, samples_checked = 0, r, n;
   // Rows: {lsb,cpol,cpha}, sent, peer byte, expected rx, expected at peer
   logic [7:0] rows [6][5] = '{'{8'h00, 8'ha5, 8'h3c, 8'h3c, 8'ha5}, '{8'h01, 8'h96, 8'h81, 8'h81, 8'h96},
      '{8'h02, 8'h0f, 8'hf0, 8'hf0, 8'h0f}, '{8'h03, 8'h5a, 8'hc3, 8'hc3, 8'h5a},
      '{8'h04, 8'h01, 8'h80, 8'h80, 8'h01}, '{8'h07, 8'he1, 8'h17, 8'h17, 8'he1}};
   sms_top sms_top_i (.core_clk(core_clk), .reset_n(reset_n), .enable(enable), .master_mode(master_mode),
      .cpol(cpol), .cpha(cpha), .lsb_first_option(lsb), .int_src_sel(int_src_sel), .int_enable(int_enable),
      .clk2x_tick(clk2x_tick), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_rd(rx_rd),
      .rx_data_r(rx_data_r), .stat_rd(stat_rd), .status_r(status_r), .irq_r(irq_r), .sclk_out_r(sclk_out_r),
      .miso_in(miso), .sclk_in(sclk_in), .mosi_in(mosi_in), .ss_in_n(ss_in_n), .ser_out_r(ser_out_r));
   sms_peer sms_peer_i (.sclk(sclk_out_r), .mosi(ser_out_r), .miso(miso), .cpol(cpol), .cpha(cpha),
      .lsb(lsb), .arm(arm), .tx_byte(pb), .rx_byte(prx));
   // Clock
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // Half-bit ticks every other cycle while allowed
   always @(posedge core_clk) clk2x_tick <= tick_en & ~clk2x_tick;
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic print_verdict;
      if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   // Bounded wait for a status bit
   task automatic wait_bit(input int b);
      int i;
      for (i = 0; i < 3000 && status_r[b] !== 1'b1; i++) @(negedge core_clk);
      if (i == 3000) begin
         n_mismatch++;
         print_verdict();
      end
   endtask : wait_bit
   // Status read or receive read pulse
   task automatic rd(input bit st);
      @(posedge core_clk);
      if (st) stat_rd <= 1'b1;
      else rx_rd <= 1'b1;
      @(posedge core_clk);
      {stat_rd, rx_rd} <= 2'b00;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
   endtask : rd
   // Mode and peer byte, then arm the peer
   task automatic go(input logic [2:0] m, input logic [7:0] p);
      @(posedge core_clk);
      arm <= 1'b0;
      {lsb, cpol, cpha} <= m;
      pb <= p;
      repeat (2) @(posedge core_clk);
      arm <= 1'b1;
   endtask : go
   task automatic wr(input logic [7:0] d);
      tx_data <= d;
      tx_valid <= 1'b1;
      @(posedge core_clk);
      tx_valid <= 1'b0;
   endtask : wr
   // External master frame in mode 0 (c low) or mode 3 (c high), 6 cycles a phase
   task automatic sframe(input logic [7:0] m, input bit c, input bit t);
      int b;
      @(posedge core_clk);
      ss_in_n <= 1'b0;
      for (b = 7; b >= 0; b--) begin
         mosi_in <= m[b];
         if (c) sclk_in <= 1'b0;
         repeat (6) @(posedge core_clk);
         sg = {sg[6:0], ser_out_r};
         sclk_in <= 1'b1;
         repeat (6) @(posedge core_clk);
         if (!c) sclk_in <= 1'b0;
      end
      repeat (6) @(posedge core_clk);
      if (!t) ss_in_n <= 1'b1;
   endtask : sframe
   initial begin
      {reset_n, enable, master_mode, cpol, cpha, lsb, int_src_sel, int_enable, tick_en} = 9'h0;
      {clk2x_tick, tx_valid, rx_rd, stat_rd, sclk_in, mosi_in, arm} = 7'h0;
      {ss_in_n, tx_data, pb, sg} = {1'b1, 24'h0};
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      chk("status", STATUS_RST, status_r);
      chk("tx_ready", 8'h01, {7'h0, tx_ready});
      @(posedge core_clk);
      {reset_n, enable, master_mode, tick_en} <= 4'hf;
      // Master rows: every mode and bit order
      for (r = 0; r < 6; r++) begin
         go(rows[r][0][2:0], rows[r][2]);
         wr(rows[r][1]);
         wait_bit(ST_DONE);
         chk("rx_data", rows[r][3], rx_data_r);
         chk("peer_rx", rows[r][4], prx);
         rd(1'b1);
         rd(1'b0);
         chk("status", 8'h10, status_r);
      end
      // Back-to-back: second byte waits in the buffer
      go(3'h0, 8'h77);
      tx_data <= 8'h3c;
      tx_valid <= 1'b1;
      @(posedge core_clk);
      tx_data <= 8'hc3;
      @(posedge core_clk);
      tx_valid <= 1'b0;
      wait_bit(ST_DONE);
      chk("rx_data", 8'h77, rx_data_r);
      rd(1'b1);
      chk("status", 8'h18, status_r);
      wait_bit(ST_DONE);
      chk("rx_data", 8'h00, rx_data_r);
      chk("peer_rx", 8'hc3, prx);
      rd(1'b1);
      rd(1'b0);
      // Fill with the engine held until refused
      @(posedge core_clk);
      {enable, tx_valid, n} <= {2'b01, 32'h0};
      for (r = 0; r < 24; r++) begin
         tx_data <= n[7:0];
         @(negedge core_clk);
         if (tx_ready === 1'b1) n++;
         @(posedge core_clk);
      end
      tx_valid <= 1'b0;
      chk("accepted", 8'(FIFO_DEPTH + 1), n[7:0]);
      // Drain in order with ticks stalled for a while
      tick_en <= 1'b0;
      go(3'h0, 8'h00);
      enable <= 1'b1;
      repeat (20) @(posedge core_clk);
      tick_en <= 1'b1;
      for (r = 0; r < n; r++) begin
         wait_bit(ST_DONE);
         chk("peer_rx", r[7:0], prx);
         rd(1'b1);
      end
      rd(1'b0);
      // Interrupt on empty buffer, masked, then on completion
      @(posedge core_clk);
      int_enable <= 1'b1;
      repeat (3) @(negedge core_clk);
      chk("irq", 8'h01, {7'h0, irq_r});
      // A buffer write drops the empty cause until the shifter takes it
      @(posedge core_clk);
      wr(8'h55);
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      chk("irq", 8'h00, {7'h0, irq_r});
      wait_bit(ST_DONE);
      rd(1'b1);
      rd(1'b0);
      @(posedge core_clk);
      {int_enable, int_src_sel} <= 2'b01;
      repeat (3) @(negedge core_clk);
      chk("irq", 8'h00, {7'h0, irq_r});
      @(posedge core_clk);
      int_enable <= 1'b1;
      wr(8'h42);
      wait_bit(ST_DONE);
      repeat (3) @(negedge core_clk);
      chk("irq", 8'h01, {7'h0, irq_r});
      rd(1'b1);
      chk("irq", 8'h00, {7'h0, irq_r});
      rd(1'b0);
      // Slave role on the external clock
      @(posedge core_clk);
      {master_mode, int_src_sel} <= 2'b00;
      go(3'h0, 8'h00);
      wr(8'h5a);
      repeat (4) @(posedge core_clk);
      sframe(8'ha3, 1'b0, 1'b0);
      wait_bit(ST_RX_FULL);
      chk("slave_rx", 8'ha3, rx_data_r);
      chk("slave_tx", 8'h5a, sg);
      repeat (3) @(negedge core_clk);
      chk("irq", 8'h01, {7'h0, irq_r});
      rd(1'b0);
      chk("irq", 8'h00, {7'h0, irq_r});
      // Mode 3 slave, select held low across two bytes
      @(posedge core_clk);
      sclk_in <= 1'b1;
      go(3'h3, 8'h00);
      wr(8'h96);
      repeat (4) @(posedge core_clk);
      sframe(8'h3c, 1'b1, 1'b1);
      wait_bit(ST_RX_FULL);
      chk("slave_rx", 8'h3c, rx_data_r);
      chk("slave_tx", 8'h96, sg);
      rd(1'b0);
      @(posedge core_clk);
      wr(8'h69);
      repeat (4) @(posedge core_clk);
      sframe(8'hc5, 1'b1, 1'b0);
      wait_bit(ST_RX_FULL);
      chk("slave_rx", 8'hc5, rx_data_r);
      chk("slave_tx", 8'h69, sg);
      rd(1'b0);
      print_verdict();
   end
endmodule : spi_master_slave_block_test
